// [hw/purs_pkg_sync.sv]
// Sequencer constants package and three-stage pin input synchroniser
package purs_pkg;
	// Timing
	localparam int unsigned CLK_HZ      = 10_000_000;
	localparam int unsigned DELAY_MS    = 60;
	localparam int unsigned DELAY_CYC   = DELAY_MS * (CLK_HZ / 1000);
	localparam int unsigned PARK_US     = 100;
	localparam int unsigned PARK_CYC    = PARK_US * (CLK_HZ / 1_000_000);
	localparam int unsigned CNT_W       = 20;

	// Register offsets
	localparam logic [7:0]  ADDR_CTRL   = 8'h00;
	localparam logic [7:0]  ADDR_STATUS = 8'h04;
	localparam logic [7:0]  ADDR_ISTAT  = 8'h08;
	localparam logic [7:0]  ADDR_IMASK  = 8'h0c;

	// Control fields
	localparam int unsigned CTRL_LV     = 0;
	localparam int unsigned CTRL_PERIPH = 1;
	localparam int unsigned CTRL_DRAM   = 2;
	localparam int unsigned CTRL_LP     = 3;

	// Interrupt fields
	localparam int unsigned IRQ_W       = 3;
	localparam int unsigned IRQ_WARN    = 0;
	localparam int unsigned IRQ_BOOT    = 1;
	localparam int unsigned IRQ_WDOG    = 2;

	// Reset values
	localparam logic [2:0]  IRQ_RST     = 3'h0;
	localparam logic [31:0] RDATA_RST   = 32'h0;

	typedef enum logic [1:0] {
		ST_OFF  = 2'b00,
		ST_PLL  = 2'b01,
		ST_RUN  = 2'b10,
		ST_PARK = 2'b11
	} purs_state_t;
endpackage

`timescale 1ns/100ps
module purs_sync #(
	parameter logic RST_VAL = 1'b0
) (
	input  wire logic i_ref_clk,
	input  wire logic i_nrst,
	input  wire logic i_pin,
	output logic      o_level
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			s1_r    <= RST_VAL;
			s2_r    <= RST_VAL;
			s3_r    <= RST_VAL;
			o_level <= RST_VAL;
		end else begin
			s1_r <= i_pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
			// Accept only when stages two and three agree
			if (s2_r == s3_r) begin
				o_level <= s3_r;
			end
		end
	end
endmodule

// [hw/purs_seq.sv]
// Power-up and system reset sequencer top
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/100ps

// Operation
// - While power-on sense is low every pin is released to high impedance; the code first lets a park in progress run to its end.
// - A rising edge on power-on sense takes the primary PLL out of reset.
// - All other logic stays in reset 60 ms after that edge, then the processor resets release.
// - After initialization the processor clocks run and its resets are released.
// - Peripheral clocks stay off and their resets held until the processor releases them.
// - After initialization every gated power domain is switched on.
// - A system reset without power loss, such as a watchdog timeout, reapplies the same defaults.
// - After low-power mode the 1.8V domain stays off past reset until software turns it on.
// - Software turns on the 1.8V domain, then the peripheral clocks, then DRAM init, in order.
// - A supply fail warning parks the micromirror array and then puts the system in reset.
module purs_seq #(
	parameter int unsigned P_DELAY_CYC = purs_pkg::DELAY_CYC
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_power_on_sense,
	input  wire logic        i_supply_fail_warning,
	input  wire logic        i_wdog_rst,
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic [31:0]      o_rdata,
	output logic             o_pin_oe_n,
	output logic             o_pll_rst_n,
	output logic             o_cpu_rst_n,
	output logic             o_cpu_clk_en,
	output logic             o_pwr_gate_en,
	output logic             o_lvds_dram_pwr_en,
	output logic             o_periph_en,
	output logic             o_dram_en,
	output logic             o_park_req,
	output logic             o_irq
);
	localparam logic [purs_pkg::CNT_W-1:0] DLY_LAST  =
		purs_pkg::CNT_W'(P_DELAY_CYC - 1);
	localparam logic [purs_pkg::CNT_W-1:0] PARK_LAST =
		purs_pkg::CNT_W'(purs_pkg::PARK_CYC - 1);

	typedef struct packed {
		purs_pkg::purs_state_t              st;
		logic [purs_pkg::CNT_W-1:0]         cnt;
		logic                               sense_q;
		logic                               warn_q;
		logic                               lp;
		logic                               periph;
		logic                               dram;
		logic [purs_pkg::IRQ_W-1:0]         ista;
		logic [purs_pkg::IRQ_W-1:0]         imask;
		logic [31:0]                        rdata;
		logic                               oe_n;
		logic                               pll_rst_n;
		logic                               cpu_rst_n;
		logic                               cpu_clk_en;
		logic                               pg_en;
		logic                               lv_en;
		logic                               periph_en;
		logic                               dram_en;
		logic                               park;
		logic                               irq;
	} purs_regs_t;

	logic       sense_f;
	logic       warn_f;
	purs_regs_t s_r;
	purs_regs_t s_nxt;

	purs_sync #(.RST_VAL(1'b0)) u_sense_sync (
		.i_ref_clk (i_ref_clk),
		.i_nrst    (i_nrst),
		.i_pin     (i_power_on_sense),
		.o_level   (sense_f)
	);

	purs_sync #(.RST_VAL(1'b0)) u_warn_sync (
		.i_ref_clk (i_ref_clk),
		.i_nrst    (i_nrst),
		.i_pin     (i_supply_fail_warning),
		.o_level   (warn_f)
	);

	always_comb begin
		logic                       wr_ctrl;
		logic [purs_pkg::IRQ_W-1:0] ev;
		logic [purs_pkg::IRQ_W-1:0] clr;
		wr_ctrl = 1'b0;
		ev      = '0;
		clr     = '0;
		s_nxt   = s_r;

		s_nxt.sense_q = sense_f;
		s_nxt.warn_q  = warn_f;

		case (s_r.st)
			purs_pkg::ST_OFF: begin
				s_nxt.cnt = '0;
				if (sense_f && !s_r.sense_q) begin
					s_nxt.st = purs_pkg::ST_PLL;
				end
			end
			purs_pkg::ST_PLL: begin
				if (!sense_f) begin
					s_nxt.st  = purs_pkg::ST_OFF;
					s_nxt.cnt = '0;
				end else if (warn_f) begin
					s_nxt.st  = purs_pkg::ST_PARK;
					s_nxt.cnt = '0;
				end else if (s_r.cnt == DLY_LAST) begin
					s_nxt.st             = purs_pkg::ST_RUN;
					s_nxt.cnt            = '0;
					ev[purs_pkg::IRQ_BOOT] = 1'b1;
				end else begin
					s_nxt.cnt = s_r.cnt + 1'b1;
				end
			end
			purs_pkg::ST_RUN: begin
				wr_ctrl = i_wr && (i_addr == purs_pkg::ADDR_CTRL);
				if (!sense_f) begin
					s_nxt.st = purs_pkg::ST_OFF;
				end else if (warn_f) begin
					s_nxt.st  = purs_pkg::ST_PARK;
					s_nxt.cnt = '0;
				end else if (i_wdog_rst) begin
					s_nxt.st               = purs_pkg::ST_PLL;
					s_nxt.cnt              = '0;
					ev[purs_pkg::IRQ_WDOG] = 1'b1;
				end
			end
			purs_pkg::ST_PARK: begin
				if (s_r.cnt == PARK_LAST) begin
					s_nxt.cnt = '0;
					s_nxt.st  = (sense_f && !warn_f) ? purs_pkg::ST_PLL
						: purs_pkg::ST_OFF;
				end else begin
					s_nxt.cnt = s_r.cnt + 1'b1;
				end
			end
			default: begin
				s_nxt.st  = purs_pkg::ST_OFF;
				s_nxt.cnt = '0;
			end
		endcase

		if (warn_f && !s_r.warn_q && s_r.st != purs_pkg::ST_OFF) begin
			ev[purs_pkg::IRQ_WARN] = 1'b1;
		end

		// Processor owned controls
		if (wr_ctrl) begin
			s_nxt.periph = i_wdata[purs_pkg::CTRL_PERIPH];
			s_nxt.dram   = i_wdata[purs_pkg::CTRL_DRAM];
			if (i_wdata[purs_pkg::CTRL_LV]) begin
				s_nxt.lp = 1'b0;
			end else if (i_wdata[purs_pkg::CTRL_LP]) begin
				s_nxt.lp = 1'b1;
			end
		end
		if (s_nxt.st != purs_pkg::ST_RUN) begin
			s_nxt.periph = 1'b0;
			s_nxt.dram   = 1'b0;
		end
		if (s_nxt.st == purs_pkg::ST_OFF && !sense_f) begin
			s_nxt.lp = 1'b0;
		end

		// Interrupt status and mask
		if (i_wr && i_addr == purs_pkg::ADDR_ISTAT) begin
			clr = i_wdata[purs_pkg::IRQ_W-1:0];
		end
		if (i_wr && i_addr == purs_pkg::ADDR_IMASK) begin
			s_nxt.imask = i_wdata[purs_pkg::IRQ_W-1:0];
		end
		s_nxt.ista = (s_r.ista & ~clr) | ev;
		s_nxt.irq  = |(s_nxt.ista & s_nxt.imask);

		// Outputs
		s_nxt.oe_n       = (s_nxt.st == purs_pkg::ST_OFF);
		s_nxt.pll_rst_n  = (s_nxt.st != purs_pkg::ST_OFF);
		s_nxt.cpu_rst_n  = (s_nxt.st == purs_pkg::ST_RUN);
		s_nxt.cpu_clk_en = (s_nxt.st == purs_pkg::ST_RUN);
		s_nxt.pg_en      = (s_nxt.st != purs_pkg::ST_OFF);
		s_nxt.lv_en      = (s_nxt.st != purs_pkg::ST_OFF) && !s_nxt.lp;
		s_nxt.periph_en  = s_nxt.periph && s_nxt.lv_en;
		s_nxt.dram_en    = s_nxt.dram && s_nxt.periph_en;
		s_nxt.park       = (s_nxt.st == purs_pkg::ST_PARK);

		// Read data only in the cycle after the strobe
		s_nxt.rdata = purs_pkg::RDATA_RST;
		if (i_rd) begin
			case (i_addr)
				purs_pkg::ADDR_CTRL: begin
					s_nxt.rdata[purs_pkg::CTRL_LV]     = !s_r.lp;
					s_nxt.rdata[purs_pkg::CTRL_PERIPH] = s_r.periph;
					s_nxt.rdata[purs_pkg::CTRL_DRAM]   = s_r.dram;
					s_nxt.rdata[purs_pkg::CTRL_LP]     = s_r.lp;
				end
				purs_pkg::ADDR_STATUS: begin
					s_nxt.rdata[7:0] = {s_r.park, s_r.dram_en, s_r.periph_en, s_r.lv_en,
						s_r.cpu_rst_n, s_r.pll_rst_n, s_r.st};
				end
				purs_pkg::ADDR_ISTAT: begin
					s_nxt.rdata[purs_pkg::IRQ_W-1:0] = s_r.ista;
				end
				purs_pkg::ADDR_IMASK: begin
					s_nxt.rdata[purs_pkg::IRQ_W-1:0] = s_r.imask;
				end
				default: begin
					s_nxt.rdata = purs_pkg::RDATA_RST;
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			s_r            <= '0;
			s_r.st         <= purs_pkg::ST_OFF;
			s_r.ista       <= purs_pkg::IRQ_RST;
			s_r.imask      <= purs_pkg::IRQ_RST;
			s_r.rdata      <= purs_pkg::RDATA_RST;
			s_r.oe_n       <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_rdata            = s_r.rdata;
	assign o_pin_oe_n         = s_r.oe_n;
	assign o_pll_rst_n        = s_r.pll_rst_n;
	assign o_cpu_rst_n        = s_r.cpu_rst_n;
	assign o_cpu_clk_en       = s_r.cpu_clk_en;
	assign o_pwr_gate_en      = s_r.pg_en;
	assign o_lvds_dram_pwr_en = s_r.lv_en;
	assign o_periph_en        = s_r.periph_en;
	assign o_dram_en          = s_r.dram_en;
	assign o_park_req         = s_r.park;
	assign o_irq              = s_r.irq;

	// Checks
	sequence s_warn_in_run;
		s_r.st == purs_pkg::ST_RUN && warn_f && sense_f;
	endsequence

	sequence s_parking;
		o_park_req [*2];
	endsequence

	sequence s_sense_rise;
		s_r.st == purs_pkg::ST_OFF && sense_f && !s_r.sense_q;
	endsequence

	a_pins_tristate: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		s_r.st == purs_pkg::ST_OFF |-> o_pin_oe_n && !o_cpu_rst_n && !o_pll_rst_n)
		else $error("pins not tristated in reset");

	a_pll_release: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		s_sense_rise |=> o_pll_rst_n && !o_cpu_rst_n)
		else $error("pll not released on sense rise");

	a_cpu_hold: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		s_r.st == purs_pkg::ST_PLL && s_r.cnt < DLY_LAST |=> !o_cpu_rst_n)
		else $error("cpu released before delay");

	a_cpu_release: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		s_r.st == purs_pkg::ST_PLL && s_r.cnt == DLY_LAST && sense_f && !warn_f
		|=> o_cpu_rst_n && o_cpu_clk_en && s_r.ista[purs_pkg::IRQ_BOOT])
		else $error("cpu not released at delay end");

	a_run_mode: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		$rose(o_cpu_rst_n) |-> o_cpu_clk_en && o_pll_rst_n && !o_pin_oe_n)
		else $error("run mode incomplete");

	a_periph_default: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		$rose(o_cpu_rst_n) |-> !o_periph_en && !o_dram_en)
		else $error("peripherals on at boot");

	a_gate_default: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		o_pll_rst_n |-> o_pwr_gate_en)
		else $error("gated domain off");

	a_wdog_defaults: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		s_r.st == purs_pkg::ST_RUN && i_wdog_rst && sense_f && !warn_f
		|=> !o_cpu_rst_n && !o_periph_en && o_pll_rst_n ##1 !o_cpu_rst_n)
		else $error("watchdog defaults missing");

	a_lp_hold: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		s_r.lp && s_r.st == purs_pkg::ST_PLL && !i_wr |=> !o_lvds_dram_pwr_en)
		else $error("1.8V on after low power reset");

	a_enable_order: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		o_dram_en |-> o_periph_en && o_lvds_dram_pwr_en && o_cpu_rst_n)
		else $error("enable order broken");

	a_park_first: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		s_warn_in_run |=> s_parking ##0 !o_cpu_rst_n)
		else $error("no park on supply warning");

	a_restart: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		s_r.st == purs_pkg::ST_PLL && !sense_f |=> s_r.st == purs_pkg::ST_OFF && s_r.cnt == '0)
		else $error("delay not restarted");
endmodule

// [dv/purs_supply_mon.sv]
// Supply monitor model driving power-on sense and the fail warning
`timescale 1ns/100ps
module purs_supply_mon #(
	parameter int SETTLE = 4,
	parameter int LEAD   = 1500
) (
	input  wire logic i_ref_clk,
	input  wire logic i_rails_up,
	input  wire logic i_brownout,
	output logic      o_power_on_sense,
	output logic      o_supply_fail_warning
);
	int cnt  = 0;
	int lead = 0;
	always @(posedge i_ref_clk) begin
		cnt <= i_rails_up ? cnt + 1 : 0;
		lead <= i_brownout ? lead + 1 : 0;
		o_supply_fail_warning <= i_brownout;
		o_power_on_sense <= i_rails_up && cnt >= SETTLE && lead < LEAD;
	end
endmodule

// [dv/test_purs_seq.sv]
// Self-checking bench for the power-up reset sequencer
`timescale 1ns/100ps
module test_purs_seq;
	localparam int P = 20;
	logic        clk, nrst, rails, brown, wdog, wr, rd, sense, warn;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata, d, r;
	logic        oe_n, pll_n, cpu_n, cpu_clk, gate, lv, per, dram, park, irq;
	int          n_errors = 0;
	int          checked  = 0;
	int          n;
	wire  [3:0]  watch = {park, cpu_n, pll_n, oe_n};

	purs_supply_mon #(.SETTLE(4), .LEAD(1500)) mon (.i_ref_clk(clk), .i_rails_up(rails),
		.i_brownout(brown), .o_power_on_sense(sense), .o_supply_fail_warning(warn));
	purs_seq #(.P_DELAY_CYC(P)) dut (.i_ref_clk(clk), .i_nrst(nrst),
		.i_power_on_sense(sense), .i_supply_fail_warning(warn), .i_wdog_rst(wdog),
		.i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.o_pin_oe_n(oe_n), .o_pll_rst_n(pll_n), .o_cpu_rst_n(cpu_n), .o_cpu_clk_en(cpu_clk),
		.o_pwr_gate_en(gate), .o_lvds_dram_pwr_en(lv), .o_periph_en(per), .o_dram_en(dram),
		.o_park_req(park), .o_irq(irq));

	function automatic logic exp_irq(input logic [2:0] st, input logic [2:0] mk);
		return |(st & mk);
	endfunction

	task automatic cmp1(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask

	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic wait_lvl(input int sel, input logic lvl, output int k);
		k = 0;
		#1;
		while (watch[sel] !== lvl && k < 5000) begin
			@(posedge clk);
			#1;
			k++;
		end
		if (k == 5000) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, watch[sel], lvl);
		end
	endtask

	task automatic pulse_wdog();
		@(posedge clk);
		wdog <= 1'b1;
		@(posedge clk);
		wdog <= 1'b0;
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	initial begin
		#2000000;
		n_errors++;
		end_of_test();
	end

	initial begin
		{nrst, rails, brown, wdog, wr, rd} = 6'h0;
		addr = 8'h0;
		wdata = 32'h0;
		void'($urandom(32'h6cafec23));
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		repeat (10) @(posedge clk);
		#1;
		cmp1(oe_n, 1'b1);
		cmp1(pll_n, 1'b0);
		// Power up, lose sense mid-wait, then power up again
		@(posedge clk) rails <= 1'b1;
		wait_lvl(1, 1'b1, n);
		cmp1(oe_n, 1'b0);
		cmp1(gate, 1'b1);
		cmp1(lv, 1'b1);
		repeat (P / 2) @(posedge clk);
		#1;
		cmp1(cpu_n, 1'b0);
		@(posedge clk) rails <= 1'b0;
		wait_lvl(1, 1'b0, n);
		cmp1(oe_n, 1'b1);
		@(posedge clk) rails <= 1'b1;
		wait_lvl(1, 1'b1, n);
		cmp1(cpu_n, 1'b0);
		wait_lvl(2, 1'b1, n);
		cmp1(n inside {[P:P + 1]}, 1'b1);
		cmp1(cpu_clk, 1'b1);
		cmp1(per | dram, 1'b0);
		rd_reg(8'h04, d);
		cmp32(d, 32'h1e);
		// DRAM enable alone stays off until the peripheral enable is written with it
		wr_reg(8'h00, 32'h4);
		settle();
		cmp1(dram, 1'b0);
		wr_reg(8'h00, 32'h6);
		settle();
		cmp1(per & dram, 1'b1);
		// Random masks against the boot status bit
		for (int i = 0; i < 6; i++) begin
			d = $urandom;
			wr_reg(8'h0c, d);
			rd_reg(8'h0c, r);
			cmp32(r, {29'h0, d[2:0]});
			settle();
			cmp1(irq, exp_irq(3'h2, d[2:0]));
		end
		wr_reg(8'h08, 32'h2);
		rd_reg(8'h08, r);
		cmp32(r, 32'h0);
		rd_reg(8'h10, r);
		cmp32(r, 32'h0);
		// Watchdog reset reapplies defaults
		pulse_wdog();
		wait_lvl(2, 1'b0, n);
		cmp1(per, 1'b0);
		cmp1(lv & gate, 1'b1);
		wait_lvl(2, 1'b1, n);
		cmp1(n inside {[P - 1:P + 2]}, 1'b1);
		rd_reg(8'h08, r);
		cmp32(r, 32'h6);
		// Low-power entry survives a watchdog reset
		wr_reg(8'h00, 32'h8);
		settle();
		cmp1(lv, 1'b0);
		pulse_wdog();
		wait_lvl(2, 1'b0, n);
		wait_lvl(2, 1'b1, n);
		cmp1(lv, 1'b0);
		wr_reg(8'h00, 32'h2);
		settle();
		cmp1(per, 1'b0);
		wr_reg(8'h00, 32'h3);
		settle();
		cmp1(lv & per, 1'b1);
		// Fail warning parks then resets
		wr_reg(8'h0c, 32'h1);
		@(posedge clk) brown <= 1'b1;
		wait_lvl(3, 1'b1, n);
		cmp1(n <= 8, 1'b1);
		cmp1(cpu_n | per, 1'b0);
		settle();
		cmp1(irq, 1'b1);
		wait_lvl(0, 1'b1, n);
		cmp1(n inside {[990:1010]}, 1'b1);
		@(posedge clk) rails <= 1'b0;
		brown <= 1'b0;
		// Warning during the PLL wait parks, then the wait restarts
		repeat (8) @(posedge clk);
		rails <= 1'b1;
		wait_lvl(1, 1'b1, n);
		@(posedge clk) brown <= 1'b1;
		repeat (8) @(posedge clk);
		brown <= 1'b0;
		wait_lvl(3, 1'b1, n);
		cmp1(n <= 2, 1'b1);
		cmp1(cpu_n | per, 1'b0);
		wait_lvl(3, 1'b0, n);
		cmp1(n inside {[990:1010]}, 1'b1);
		cmp1(pll_n & ~oe_n, 1'b1);
		wait_lvl(2, 1'b1, n);
		cmp1(n inside {[P:P + 1]}, 1'b1);
		// Power loss clears low-power mode
		wr_reg(8'h00, 32'h8);
		settle();
		cmp1(lv, 1'b0);
		@(posedge clk) rails <= 1'b0;
		wait_lvl(1, 1'b0, n);
		cmp1(oe_n, 1'b1);
		@(posedge clk) rails <= 1'b1;
		wait_lvl(1, 1'b1, n);
		cmp1(lv, 1'b1);
		@(posedge clk) rails <= 1'b0;
		settle();
		end_of_test();
	end
endmodule
